// >>> dfp_consts.svh
// Constants for the converter fault, protection and power-down block.
// Assumes inclusion by the package, the top module and the bench only.
//
// Summary of operation
// - Status byte heads every echoed word
// - Status refreshed each frame, shown next frame
// - Cleared fault shows cleared next frame
// - Alert pulled low on any fault
// - Alert released at next select rising edge
// - Bits 0-4 flag per-channel open circuit
// - Overtemp sets bit 5, powers down, alerts
// - Overtemp holds until die cools
// - Bad frame length sets bit 7, ignored
// - Bit 6 reserved, always zero
// - Command 0111 sets protection configuration
// - Open-detect disable masks bits 0-4
// - Thermal disable stops overtemp detection
// - External reference select switches reference
// - Power-down turns drivers off, keeps registers
// - Command 0100 powers down addressed channel
// - Command 0101 powers down chip, reference
// - Power-down commands ignore data field
// - Update wakes a powered-down channel
// - Status byte replaces echoed prefix byte
// - External reference select resets to zero
`ifndef DFP_CONSTS_SVH
`define DFP_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define DFP_NCH          5
`define DFP_WORD_W       32
`define DFP_INSTR_W      24
`define DFP_SHORT_LEN    5'h18

// ----------------------------------------
// Command codes
// ----------------------------------------
`define DFP_CMD_UPD_N    4'h1
`define DFP_CMD_WRUPD_N  4'h3
`define DFP_CMD_PD_CH    4'h4
`define DFP_CMD_PD_CHIP  4'h5
`define DFP_CMD_CONFIG   4'h7
`define DFP_CMD_UPD_ALL  4'h9
`define DFP_CMD_WRUPD_AL 4'ha

// ----------------------------------------
// Status byte positions and config data bits
// ----------------------------------------
`define DFP_ST_OT        5
`define DFP_ST_RSV       6
`define DFP_ST_BADLEN    7
`define DFP_CFG_EXTREF   0
`define DFP_CFG_TSDIS    1
`define DFP_CFG_OCDIS    2
`define DFP_CFG_RST      3'h0

`endif

// >>> dfp_fault_pd_ctrl.sv
// Fault status, alert pin, protection config and power-down control.
// Assumes a host drives sck, sdi and select_load_n asynchronously and
// that detector inputs are comparator levels from the analog side.
`timescale 1ns/1ps
`include "dfp_consts.svh"

module dfp_fault_pd_ctrl
	import dfp_pkg::*;
(
	input  wire logic                core_clk,       // System clock
	input  wire logic                arst_n,         // Async reset
	input  wire logic                sck,            // Serial clock pin
	input  wire logic                sdi,            // Serial data in pin
	input  wire logic                select_load_n,  // Frame select pin
	input  wire logic [`DFP_NCH-1:0] open_det,       // Dropout comparators
	input  wire logic                overtemp_det,   // Hysteretic temp comparator
	input  wire logic [`DFP_NCH-1:0] toggle_upd,     // Toggle update pulses
	output logic                     sdo_bit,        // Serial data out
	output logic                     sdo_oe,         // Serial out enable
	output logic                     fault_n_drv,    // Alert pin level
	output logic                     fault_n_oe,     // Alert pull-down enable
	output logic [`DFP_NCH-1:0]      chan_off,       // Channel drivers off
	output logic                     ref_pd,         // Reference powered down
	output logic                     ext_ref_sel,    // External reference in use
	output logic [7:0]               fault_status_byte // Live status byte
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------

	// Channel mask from address, none for out-of-range
	function automatic logic [`DFP_NCH-1:0] addr_mask(input logic [3:0] a);
		logic [`DFP_NCH-1:0] m;
		m = '0;
		if (a < 4'(`DFP_NCH)) begin
			m[a[2:0]] = 1'b1;
		end
		return m;
	endfunction

	// Channels that a command updates
	function automatic logic [`DFP_NCH-1:0] upd_mask(input dfp_instr_t i);
		logic [`DFP_NCH-1:0] m;
		m = '0;
		unique case (i.cmd)
			`DFP_CMD_UPD_N, `DFP_CMD_WRUPD_N: begin
				m = addr_mask(i.addr);
			end
			`DFP_CMD_UPD_ALL, `DFP_CMD_WRUPD_AL: begin
				m = '1;
			end
			default: begin
				m = '0;
			end
		endcase
		return m;
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------

	logic [2:0]           sck_s_r;    // Sync pair plus edge history
	logic [1:0]           sdi_s_r;    // Sync pair
	logic [2:0]           csn_s_r;    // Sync pair plus edge history
	logic [`DFP_NCH-1:0]  oc_s1_r;    // First stage open detect
	logic [`DFP_NCH-1:0]  oc_s2_r;    // Second stage open detect
	logic [1:0]           ot_s_r;     // Overtemp sync pair

	// Two flops on every outside level
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sck_s_r <= 3'h0;
			sdi_s_r <= 2'h0;
			csn_s_r <= 3'h7;
			oc_s1_r <= '0;
			oc_s2_r <= '0;
			ot_s_r  <= 2'h0;
		end else begin
			sck_s_r <= {sck_s_r[1:0], sck};
			sdi_s_r <= {sdi_s_r[0], sdi};
			csn_s_r <= {csn_s_r[1:0], select_load_n};
			oc_s1_r <= open_det;
			oc_s2_r <= oc_s1_r;
			ot_s_r  <= {ot_s_r[0], overtemp_det};
		end
	end

	logic sck_rise;  // Serial clock rising
	logic sck_fall;  // Serial clock falling
	logic csn_fall;  // Frame start
	logic csn_rise;  // Frame end
	assign sck_rise = sck_s_r[1] & ~sck_s_r[2];
	assign sck_fall = ~sck_s_r[1] & sck_s_r[2];
	assign csn_fall = ~csn_s_r[1] & csn_s_r[2];
	assign csn_rise = csn_s_r[1] & ~csn_s_r[2];

	// ----------------------------------------
	// Live status
	// ----------------------------------------

	dfp_cfg_t            cfg_r;        // Protection configuration
	logic                bad_len_r;    // Last frame had bad length
	logic                thermal_act;  // Overtemp in force
	logic [7:0]          status_live;  // Status as it stands now

	// Comparator hysteresis holds the level until cool-down
	assign thermal_act = ot_s_r[1] & ~cfg_r.ts_dis;

	always_comb begin
		status_live                = '0;
		status_live[`DFP_NCH-1:0]  = oc_s2_r & {`DFP_NCH{~cfg_r.oc_dis}};
		status_live[`DFP_ST_OT]    = thermal_act;
		status_live[`DFP_ST_RSV]   = 1'b0;
		status_live[`DFP_ST_BADLEN] = bad_len_r;
	end

	// ----------------------------------------
	// Frame receive
	// ----------------------------------------

	dfp_link_t                link_r;    // Frame phase
	logic [`DFP_INSTR_W-1:0]  in_sr_r;   // Last 24 bits shifted in
	logic [4:0]               cnt_r;     // Bit count modulo 32
	logic                     wrap_r;    // Count reached 32 at least once
	logic                     len_ok;    // Frame length acceptable
	logic                     exec;      // Accepted frame ends now
	logic                     reject;    // Bad frame ends now
	dfp_instr_t               instr;     // Decoded instruction

	assign len_ok = (!wrap_r && cnt_r == `DFP_SHORT_LEN) || (wrap_r && cnt_r == 5'h0);
	assign exec   = csn_rise && link_r == LINK_SHIFT && len_ok;
	assign reject = csn_rise && link_r == LINK_SHIFT && !len_ok;
	assign instr  = in_sr_r;

	// Frame phase follows the select line
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			link_r <= LINK_IDLE;
		end else begin
			unique case (link_r)
				LINK_IDLE: begin
					if (csn_fall) begin
						link_r <= LINK_SHIFT;
					end
				end
				LINK_SHIFT: begin
					if (csn_rise) begin
						link_r <= LINK_IDLE;
					end
				end
			endcase
		end
	end

	// Input shift and bit counting
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			in_sr_r <= '0;
			cnt_r   <= 5'h0;
			wrap_r  <= 1'b0;
		end else if (csn_fall) begin
			cnt_r  <= 5'h0;
			wrap_r <= 1'b0;
		end else if (link_r == LINK_SHIFT && sck_rise) begin
			in_sr_r <= {in_sr_r[`DFP_INSTR_W-2:0], sdi_s_r[1]};
			cnt_r   <= cnt_r + 5'h1;
			if (cnt_r == 5'h1f) begin
				wrap_r <= 1'b1;
			end
		end
	end

	// Length flag follows each frame
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bad_len_r <= 1'b0;
		end else if (reject) begin
			bad_len_r <= 1'b1;
		end else if (exec) begin
			bad_len_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Echo output
	// ----------------------------------------

	logic [`DFP_INSTR_W-1:0]  prev_r;    // Last accepted instruction
	logic [`DFP_WORD_W-1:0]   out_sr_r;  // Outgoing word and delay line

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_r <= '0;
		end else if (exec) begin
			prev_r <= in_sr_r;
		end
	end

	// Status snapshot leads the echoed instruction
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_sr_r <= '0;
			sdo_bit  <= 1'b0;
		end else if (csn_fall) begin
			out_sr_r <= {status_live, prev_r};
			sdo_bit  <= status_live[7];
		end else if (link_r == LINK_SHIFT) begin
			if (sck_rise) begin
				out_sr_r <= {out_sr_r[`DFP_WORD_W-2:0], sdi_s_r[1]};
			end
			if (sck_fall) begin
				sdo_bit <= out_sr_r[`DFP_WORD_W-1];
			end
		end
	end

	// Output released outside frames
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= csn_fall | (link_r == LINK_SHIFT && !csn_rise);
		end
	end

	// ----------------------------------------
	// Alert pin
	// ----------------------------------------

	logic [5:0] st_prev_r;  // Previous detector flags
	logic       fault_evt;  // New fault this cycle

	assign fault_evt = (|(status_live[5:0] & ~st_prev_r)) | reject;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_prev_r <= 6'h0;
		end else begin
			st_prev_r <= status_live[5:0];
		end
	end

	// New fault wins over a release in the same cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_n_oe <= 1'b0;
		end else if (fault_evt) begin
			fault_n_oe <= 1'b1;
		end else if (csn_rise) begin
			fault_n_oe <= 1'b0;
		end
	end

	// Open drain only ever pulls low
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_n_drv <= 1'b0;
		end else begin
			fault_n_drv <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration and power-down
	// ----------------------------------------

	logic [`DFP_NCH-1:0] chan_pd_r;  // Channel power-down state
	logic [`DFP_NCH-1:0] wake;       // Channels updated this cycle

	// Config command, ignored on bad frames
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r <= `DFP_CFG_RST;
		end else if (exec && instr.cmd == `DFP_CMD_CONFIG) begin
			cfg_r.oc_dis  <= instr.data[`DFP_CFG_OCDIS];
			cfg_r.ts_dis  <= instr.data[`DFP_CFG_TSDIS];
			cfg_r.ext_ref <= instr.data[`DFP_CFG_EXTREF];
		end
	end

	// Update commands and toggle events wake channels
	assign wake = toggle_upd | (exec ? upd_mask(instr) : '0);

	// Power-down state, data field never looked at
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_pd_r <= '0;
			ref_pd    <= 1'b0;
		end else if (thermal_act) begin
			chan_pd_r <= '1;
		end else if (exec && instr.cmd == `DFP_CMD_PD_CH) begin
			chan_pd_r <= chan_pd_r | addr_mask(instr.addr);
		end else if (exec && instr.cmd == `DFP_CMD_PD_CHIP) begin
			chan_pd_r <= '1;
			ref_pd    <= 1'b1;
		end else if (|wake) begin
			chan_pd_r <= chan_pd_r & ~wake;
			ref_pd    <= 1'b0;
		end
	end

	// Drivers off while powered down or overheated
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_off          <= '0;
			ext_ref_sel       <= 1'b0;
			fault_status_byte <= 8'h0;
		end else begin
			chan_off          <= chan_pd_r | {`DFP_NCH{thermal_act}};
			ext_ref_sel       <= cfg_r.ext_ref;
			fault_status_byte <= status_live;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_frame_end_ok;
		exec && !fault_evt;
	endsequence

	sequence s_pins_released;
		!fault_n_oe ##1 !fault_n_oe;
	endsequence

	a_alert_release: assert property (s_frame_end_ok ##1 !fault_evt |-> s_pins_released)
		else $error("alert not released after frame end");
	a_alert_assert: assert property (fault_evt |=> fault_n_oe)
		else $error("alert not pulled on fault");
	a_bad_len_flag: assert property (reject |=> bad_len_r && fault_n_oe)
		else $error("bad length not flagged");
	a_bad_len_drop: assert property (reject |=> $stable(cfg_r) && $stable(prev_r))
		else $error("bad frame was executed");
	a_status_head: assert property (csn_fall |=> out_sr_r[31:24] == $past(status_live))
		else $error("status byte not at head of word");
	a_echo_prev: assert property (csn_fall |=> out_sr_r[23:0] == $past(prev_r))
		else $error("echo lost previous instruction");
	a_reserved_zero: assert property (
		status_live[`DFP_ST_RSV] == 1'b0 && fault_status_byte[`DFP_ST_RSV] == 1'b0)
		else $error("reserved status bit set");
	a_oc_masked: assert property (cfg_r.oc_dis |-> status_live[4:0] == 5'h0)
		else $error("open detect not masked");
	a_ts_masked: assert property (cfg_r.ts_dis |-> !status_live[`DFP_ST_OT])
		else $error("overtemp reported while disabled");
	a_thermal_off: assert property (thermal_act |=> chan_pd_r == '1 ##1 chan_off == '1)
		else $error("overtemp did not shut channels");
	a_pd_chan: assert property (
		exec && instr.cmd == `DFP_CMD_PD_CH && instr.addr < 4'h5 && !thermal_act
		|=> chan_pd_r[$past(instr.addr[2:0])])
		else $error("channel power-down missed");
	a_pd_chip: assert property (
		exec && instr.cmd == `DFP_CMD_PD_CHIP && !thermal_act |=> chan_pd_r == '1 && ref_pd)
		else $error("chip power-down missed");
	a_wake_chan: assert property (
		|wake && !thermal_act && !exec |=> (chan_pd_r & $past(wake)) == '0)
		else $error("update did not wake channel");

endmodule

// >>> dfp_fault_pd_ctrl_tb.sv
// Self-checking bench for the fault, protection and power-down block.
// Assumes the host model and the design package are compiled first.
`timescale 1ns/1ps
`include "dfp_consts.svh"

module dfp_fault_pd_ctrl_tb
	import dfp_pkg::*;
;
	// ----------------------------------------
	// Bench signals
	// ----------------------------------------
	logic                core_clk;           // System clock
	logic                arst_n;             // Async reset
	logic                sck;                // Link clock from host
	logic                sdi;                // Link data from host
	logic                select_load_n;      // Frame select from host
	logic [`DFP_NCH-1:0] open_det;           // Dropout comparators
	logic                overtemp_det;       // Temperature comparator
	logic [`DFP_NCH-1:0] toggle_upd;         // Toggle update pulses
	logic                sdo_bit;            // Data out level
	logic                sdo_oe;             // Data out enable
	logic                fault_n_drv;        // Alert drive level
	logic                fault_n_oe;         // Alert pull-down enable
	logic [`DFP_NCH-1:0] chan_off;           // Channel drivers off
	logic                ref_pd;             // Reference off
	logic                ext_ref_sel;        // External reference chosen
	logic [7:0]          fault_status_byte;  // Live status byte
	wire                 sdo_line;           // Resolved data-out line
	wire                 alert_n;            // Resolved alert line
	logic [63:0]         rx;                 // Last echoed frame
	int                  fail_count;         // Mismatches
	int                  samples_checked;    // Comparisons

	// Pull-ups on both released lines
	assign sdo_line = sdo_oe ? sdo_bit : 1'b1;
	assign alert_n  = fault_n_oe ? fault_n_drv : 1'b1;

	// ----------------------------------------
	// Clock, design and host
	// ----------------------------------------
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	dfp_fault_pd_ctrl dut (
		.core_clk          (core_clk),
		.arst_n            (arst_n),
		.sck               (sck),
		.sdi               (sdi),
		.select_load_n     (select_load_n),
		.open_det          (open_det),
		.overtemp_det      (overtemp_det),
		.toggle_upd        (toggle_upd),
		.sdo_bit           (sdo_bit),
		.sdo_oe            (sdo_oe),
		.fault_n_drv       (fault_n_drv),
		.fault_n_oe        (fault_n_oe),
		.chan_off          (chan_off),
		.ref_pd            (ref_pd),
		.ext_ref_sel       (ext_ref_sel),
		.fault_status_byte (fault_status_byte)
	);

	dfp_spi_host host (
		.clk           (core_clk),
		.sck           (sck),
		.sdi           (sdi),
		.select_load_n (select_load_n),
		.sdo           (sdo_line)
	);

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic end_sim();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// Instruction word, upper bits clear
	function automatic logic [63:0] mk(input logic [3:0] c, input logic [3:0] a,
			input logic [15:0] d);
		dfp_instr_t i;
		i = '{cmd: c, addr: a, data: d};
		return {40'h0, i};
	endfunction

	// One frame, then time for the command to land
	task automatic fr(input int n, input logic [63:0] w);
		host.xfer(n, w, rx);
		tick(8);
	endtask

	// Bounded wait for the alert line level
	task automatic alert_is(input logic exp);
		int k;
		k = 0;
		while (alert_n !== exp && k < 40) begin
			@(posedge core_clk);
			k++;
		end
		chk(alert_n, exp);
		if (alert_n !== exp) end_sim();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Echo of 24- and 32-bit frames; bad channel address ignored
	task automatic t_echo();
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
		fr(24, mk(`DFP_CMD_PD_CH, 4'h5, 16'hab12));
		chk(rx[23:0], 24'h007000);
		chk(chan_off, 5'h00);
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
		chk(rx[31:0], 32'h0045ab12);
	endtask

	// Each channel's open flag, alert pull and release
	task automatic t_open();
		for (int ch = 0; ch < `DFP_NCH; ch++) begin
			open_det <= 5'(1 << ch);
			alert_is(1'b0);
			tick(2);
			chk(fault_status_byte, 8'(1 << ch));
			fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
			chk(rx[31:24], 8'(1 << ch));
			chk(alert_n, 1'b1);
			open_det <= 5'h00;
			fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
			chk(rx[31:24], 8'h00);
		end
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0004));
		open_det <= 5'h1f;
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0004));
		chk({rx[31:24], alert_n}, {8'h00, 1'b1});
		open_det <= 5'h00;
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
	endtask

	// Overtemperature shutdown, disable, cool-down and wake
	task automatic t_temp();
		overtemp_det <= 1'b1;
		alert_is(1'b0);
		tick(4);
		chk({chan_off, fault_status_byte}, {5'h1f, 8'h20});
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0002));
		chk({rx[31:24], alert_n}, {8'h20, 1'b1});
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0002));
		chk(rx[31:24], 8'h00);
		overtemp_det <= 1'b0;
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
		chk(chan_off, 5'h1f);
		fr(32, mk(`DFP_CMD_UPD_ALL, 4'h0, 16'h0000));
		chk(chan_off, 5'h00);
	endtask

	// Refused lengths, then a valid long frame
	task automatic t_len();
		int lens[3] = '{20, 25, 40};
		foreach (lens[i]) begin
			fr(lens[i], mk(`DFP_CMD_CONFIG, 4'h0, 16'h0001));
			chk({alert_n, ext_ref_sel}, 2'b00);
			fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
			chk(rx[31:24], 8'h80);
		end
		fr(32, mk(`DFP_CMD_CONFIG, 4'h0, 16'h0000));
		chk(rx[31:24], 8'h00);
		fr(64, 64'h5a5ac3c3_00000000 | mk(`DFP_CMD_CONFIG, 4'h0, 16'h0001));
		chk(rx, 64'h00700000_5a5ac3c3);
		chk(ext_ref_sel, 1'b1);
	endtask

	// Channel and chip power-down, then wake by both single-channel updates, a toggle and write-update-all
	task automatic t_pd();
		for (int ch = 0; ch < `DFP_NCH; ch++) begin
			fr(32, mk(`DFP_CMD_PD_CH, 4'(ch), 16'hffff));
			chk({chan_off, ref_pd}, {5'((1 << (ch + 1)) - 1), 1'b0});
		end
		fr(32, mk(`DFP_CMD_PD_CHIP, 4'h0, 16'h5a5a));
		chk({chan_off, ref_pd, ext_ref_sel}, {5'h1f, 2'b11});
		fr(32, mk(`DFP_CMD_WRUPD_N, 4'h2, 16'h1000));
		chk({chan_off, ref_pd}, {5'h1b, 1'b0});
		host.wake_wait(1'b1);
		fr(32, mk(`DFP_CMD_UPD_N, 4'h4, 16'h0000));
		chk(chan_off, 5'h0b);
		toggle_upd <= 5'h08;
		tick(1);
		toggle_upd <= 5'h00;
		tick(4);
		chk(chan_off, 5'h03);
		fr(32, mk(`DFP_CMD_WRUPD_AL, 4'h0, 16'h0000));
		chk(chan_off, 5'h00);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		fail_count      = 0;
		samples_checked = 0;
		arst_n          = 1'b0;
		open_det        = 5'h00;
		overtemp_det    = 1'b0;
		toggle_upd      = 5'h00;
		tick(20);
		arst_n <= 1'b1;
		tick(3);
		chk({chan_off, ref_pd, ext_ref_sel, fault_status_byte}, 15'h0000);
		chk({sdo_oe, alert_n}, 2'b01);
		t_echo();
		t_open();
		t_temp();
		t_len();
		t_pd();
		end_sim();
	end

	// Hang guard well over the cycle budget
	initial begin
		#900000;
		fail_count++;
		end_sim();
	end
endmodule

// >>> dfp_pkg.sv
// Types shared by the fault and power-down block.
// Assumes the constants header sits in the include path.
`include "dfp_consts.svh"

package dfp_pkg;

	// Decoded instruction fields
	typedef struct packed {
		logic [3:0]  cmd;
		logic [3:0]  addr;
		logic [15:0] data;
	} dfp_instr_t;

	// Protection configuration
	typedef struct packed {
		logic oc_dis;
		logic ts_dis;
		logic ext_ref;
	} dfp_cfg_t;

	// Serial link phase
	typedef enum logic {
		LINK_IDLE,
		LINK_SHIFT
	} dfp_link_t;

endpackage

// >>> dfp_spi_host.sv
// Host controller model that drives the serial port of the fault block.
// Assumes the bench resolves the data-out line with a pull-up.
`timescale 1ns/1ps

module dfp_spi_host (
	input  wire logic clk,            // Bench system clock
	output logic      sck,            // Link clock, low outside frames
	output logic      sdi,            // Link data towards the device
	output logic      select_load_n,  // Frame select, idle high
	input  wire logic sdo             // Resolved data-out line
);
	// ----------------------------------------
	// Idle levels
	// ----------------------------------------
	initial begin
		sck           = 1'b0;
		sdi           = 1'b0;
		select_load_n = 1'b1;
	end

	// ----------------------------------------
	// Frame of n bits, MSB first
	// ----------------------------------------
	// Half period of eight system clocks gives a 160 ns link clock
	task automatic xfer(input int n, input logic [63:0] w, output logic [63:0] rx);
		rx = '0;
		@(posedge clk);
		select_load_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			sdi <= w[i];
			repeat (8) @(posedge clk);
			sck   <= 1'b1;
			rx[i] = sdo;
			repeat (8) @(posedge clk);
			sck <= 1'b0;
		end
		repeat (8) @(posedge clk);
		select_load_n <= 1'b1;
		// Data line flips once the frame is over
		sdi <= ~sdi;
		repeat (12) @(posedge clk);
	endtask

	// ----------------------------------------
	// Wake-up wait before trusting an output
	// ----------------------------------------
	// Longer after a whole-chip power-down
	task automatic wake_wait(input bit chip);
		repeat (chip ? 3500 : 3000) @(posedge clk);
	endtask
endmodule
